// ---- inc/sfm_pkg.sv ----
package sfm_pkg;
  localparam int unsigned CLK_HZ       = 20_000_000;
  localparam int unsigned DATA_W       = 16;
  localparam int unsigned FIFO_DEPTH   = 4;
  localparam int unsigned DIV_W        = 8;
  localparam logic [7:0]  DIV_DEFAULT  = 8'h04;
  localparam logic [4:0]  CNT_W_RESET  = 5'h00;

  typedef struct packed {
    logic framed_mode_enable;
    logic slave_select_pin_enable;
    logic frame_sync_polarity;
    logic clock_idle_polarity;
    logic input_sample_phase;
    logic master_role_enable;
    logic port_enable;
  } sfm_cfg_t;

  typedef struct packed {
    logic tx_buffer_empty;
    logic rx_word_ready;
    logic busy;
    logic config_error;
    logic sample_phase_active;
  } sfm_stat_t;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_SYNC  = 4'b0010,
    ST_SHIFT = 4'b0100,
    ST_DONE  = 4'b1000
  } sfm_state_t;
endpackage

// ---- rtl/sfm_fifo.sv ----
`timescale 1ns/10ps
module sfm_fifo #(
  parameter int unsigned WIDTH = 16,
  parameter int unsigned DEPTH = 4
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic [WIDTH-1:0]      out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic [AW-1:0]    next_wr_ptr;
  logic [AW-1:0]    next_rd_ptr;
  logic [AW:0]      next_count;
  logic             push;
  logic             pop;

  assign in_ready  = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data  = mem[rd_ptr];

  always_comb begin
    push        = in_valid && in_ready;
    pop         = out_valid && out_ready;
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    if (push) begin
      next_wr_ptr = (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
    end
    if (pop) begin
      next_rd_ptr = (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
    end
    next_count = count + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count  <= next_count;
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end
endmodule

// ---- rtl/sfm_port.sv ----
`timescale 1ns/10ps
module sfm_port
  import sfm_pkg::*;
#(
  parameter int unsigned WIDTH = DATA_W,
  parameter int unsigned DEPTH = FIFO_DEPTH
) (
  input  wire logic             ref_clk,
  input  wire logic             rst,
  input  wire sfm_cfg_t         cfg,
  input  wire logic [DIV_W-1:0] clk_div,
  input  wire logic [WIDTH-1:0] tx_data,
  input  wire logic             tx_valid,
  output logic                  tx_ready,
  output logic [WIDTH-1:0]      rx_data,
  output logic                  rx_valid,
  input  wire logic             rx_ack,
  output sfm_stat_t             status,
  input  wire logic             sck_in,
  output logic                  sck_out,
  output logic                  sck_oe,
  input  wire logic             sdi,
  output logic                  sdo,
  input  wire logic             ss_in,
  output logic                  ss_out,
  output logic                  ss_oe
);
  localparam int unsigned BW = $clog2(WIDTH + 1);

  logic [WIDTH-1:0] f_data;
  logic             f_valid;
  logic             f_ready;
  sfm_state_t       state;
  sfm_state_t       next_state;
  logic [DIV_W-1:0] div_cnt;
  logic [DIV_W-1:0] next_div_cnt;
  logic             tick;
  logic             sck_int;
  logic             next_sck_int;
  logic [WIDTH-1:0] shreg;
  logic [WIDTH-1:0] next_shreg;
  logic [BW-1:0]    bits;
  logic [BW-1:0]    next_bits;
  logic             smp_q;
  logic             next_smp_q;
  logic             sync_q;
  logic             next_sync_q;
  logic [WIDTH-1:0] next_rx_data;
  logic             next_rx_valid;
  logic             sck_d;
  logic             ss_d;
  logic             bad_cfg;
  logic             lead_edge;
  logic             trail_edge;
  logic             slv_rise;
  logic             slv_fall;
  logic             slv_sample;
  logic             slv_shift;
  logic             ss_active;
  logic             start;
  logic             samp_edge;
  logic             shift_edge;
  logic             rx_bit;
  logic             next_rx_bit;
  logic             in_bit;

  sfm_fifo #(.WIDTH(WIDTH), .DEPTH(DEPTH)) u_fifo (
    .clk      (ref_clk),
    .rst      (rst),
    .in_data  (tx_data),
    .in_valid (tx_valid),
    .in_ready (tx_ready),
    .out_data (f_data),
    .out_valid(f_valid),
    .out_ready(f_ready)
  );

  // The invalid pair is only flagged and blocks transfers; it is not repaired.
  assign bad_cfg = cfg.framed_mode_enable && cfg.slave_select_pin_enable;

  // Master clock edges come from a divider enable, never a second clock.
  assign tick       = cfg.master_role_enable && (div_cnt == clk_div);
  assign lead_edge  = tick && (sck_int == cfg.clock_idle_polarity);
  assign trail_edge = tick && (sck_int != cfg.clock_idle_polarity);

  assign slv_rise   = sck_in && !sck_d;
  assign slv_fall   = !sck_in && sck_d;
  assign slv_sample = cfg.clock_idle_polarity ? slv_fall : slv_rise;
  assign slv_shift  = cfg.clock_idle_polarity ? slv_rise : slv_fall;

  // Data is sampled on one edge and moved on the other, so the far side
  // never sees its input change on the edge at which it samples.
  assign samp_edge  = cfg.master_role_enable ? lead_edge : slv_sample;
  assign shift_edge = cfg.master_role_enable ? trail_edge : slv_shift;
  // Late sampling reads the input at the end of the bit, which gives the
  // far side a whole bit of setup and so suits the fastest divider.
  assign in_bit     = smp_q ? sdi : rx_bit;

  // Frame start seen on slave select at the chosen polarity.
  assign ss_active = cfg.frame_sync_polarity ? (ss_in && !ss_d)
                                              : (!ss_in && ss_d);

  always_comb begin
    start = 1'b0;
    if (cfg.port_enable && !bad_cfg && f_valid && state == ST_IDLE) begin
      if (cfg.master_role_enable) begin
        start = cfg.framed_mode_enable ? trail_edge
                : (sck_int == cfg.clock_idle_polarity);
      end else begin
        start = cfg.framed_mode_enable ? ss_active
                : (!cfg.slave_select_pin_enable || !ss_in);
      end
    end
  end

  // Buffer word leaves the FIFO the moment the shift register takes it.
  assign f_ready = start;

  always_comb begin
    next_div_cnt  = (tick || !cfg.master_role_enable) ? '0 : div_cnt + 1'b1;
    next_sck_int  = sck_int;
    next_state    = state;
    next_shreg    = shreg;
    next_bits     = bits;
    next_sync_q   = 1'b0;
    next_rx_data  = rx_data;
    next_rx_valid = rx_valid && !rx_ack;
    next_rx_bit   = rx_bit;
    // Sample phase is latched only while master enable already stands.
    next_smp_q    = cfg.input_sample_phase && cfg.master_role_enable;
    if (!cfg.port_enable || !cfg.master_role_enable) begin
      next_sck_int = cfg.clock_idle_polarity;
    end else if (tick && (cfg.framed_mode_enable || state == ST_SHIFT
                          || sck_int != cfg.clock_idle_polarity)) begin
      next_sck_int = !sck_int;
    end
    case (state)
      ST_IDLE: begin
        if (start) begin
          next_shreg  = f_data;
          next_bits   = BW'(WIDTH);
          next_sync_q = cfg.framed_mode_enable && cfg.master_role_enable;
          next_state  = ST_SHIFT;
        end
      end
      ST_SHIFT: begin
        if (samp_edge) begin
          next_rx_bit = sdi;
        end
        if (shift_edge) begin
          next_shreg = {shreg[WIDTH-2:0], in_bit};
          next_bits  = bits - 1'b1;
          if (bits == BW'(1)) begin
            next_state = ST_DONE;
          end
        end
      end
      ST_DONE: begin
        next_rx_data  = shreg;
        next_rx_valid = 1'b1;
        next_state    = ST_IDLE;
      end
      default: next_state = ST_IDLE;
    endcase
    if (!cfg.port_enable || bad_cfg) begin
      next_state = ST_IDLE;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state    <= ST_IDLE;
      div_cnt  <= '0;
      sck_int  <= 1'b0;
      shreg    <= '0;
      bits     <= CNT_W_RESET[BW-1:0];
      smp_q    <= 1'b0;
      sync_q   <= 1'b0;
      rx_data  <= '0;
      rx_valid <= 1'b0;
      sck_d    <= 1'b0;
      ss_d     <= 1'b0;
      rx_bit   <= 1'b0;
    end else begin
      state    <= next_state;
      div_cnt  <= next_div_cnt;
      sck_int  <= next_sck_int;
      shreg    <= next_shreg;
      bits     <= next_bits;
      smp_q    <= next_smp_q;
      sync_q   <= next_sync_q;
      rx_data  <= next_rx_data;
      rx_valid <= next_rx_valid;
      sck_d    <= sck_in;
      ss_d     <= ss_in;
      rx_bit   <= next_rx_bit;
    end
  end

  assign sck_out = sck_int;
  assign sck_oe  = cfg.port_enable && cfg.master_role_enable;
  assign sdo     = shreg[WIDTH-1];
  assign ss_out  = sync_q ? cfg.frame_sync_polarity
                          : !cfg.frame_sync_polarity;
  assign ss_oe   = cfg.port_enable && cfg.master_role_enable
                   && cfg.framed_mode_enable;

  always_comb begin
    status.tx_buffer_empty     = !f_valid;
    status.rx_word_ready       = rx_valid;
    status.busy                = (state != ST_IDLE);
    status.config_error        = bad_cfg;
    status.sample_phase_active = smp_q;
  end
endmodule

// ---- test/sfm_port_checker.sv ----
`timescale 1ns/10ps
module sfm_port_checker
  import sfm_pkg::*;
(
  input wire logic      ref_clk,
  input wire logic      rst,
  input wire sfm_cfg_t  cfg,
  input wire logic      tx_valid,
  input wire logic      tx_ready,
  input wire sfm_stat_t status,
  input wire logic      sck_out,
  input wire logic      ss_out,
  input wire logic      ss_oe
);
  logic mst;
  logic fr_on;
  logic act;
  assign mst = cfg.master_role_enable & cfg.port_enable;
  assign fr_on = mst & cfg.framed_mode_enable & !status.config_error;
  assign act = ss_oe & (ss_out == cfg.frame_sync_polarity);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  a_pair_flagged: assert property (
    (cfg.framed_mode_enable & cfg.slave_select_pin_enable)[*2]
    |-> status.config_error & !status.busy)
    else $error("pair not flagged");
  a_clock_runs: assert property (
    fr_on |-> ##[1:300] ($changed(sck_out) | !fr_on))
    else $error("sck stopped");
  a_sync_single: assert property (
    act & $stable(cfg) |=> !act | $changed(cfg)) else $error("long sync");
  a_phase_gated: assert property (
    $rose(status.sample_phase_active)
    |-> $past(cfg.master_role_enable & cfg.input_sample_phase))
    else $error("phase without master");
  a_phase_taken: assert property (
    (mst & cfg.input_sample_phase)[*2] |-> status.sample_phase_active)
    else $error("phase not taken");
  a_drain_starts: assert property (
    $rose(status.tx_buffer_empty) |-> ##[0:1] status.busy)
    else $error("empty without start");
  a_word_held: assert property (
    tx_valid & tx_ready |=> !status.tx_buffer_empty) else $error("word lost");
  a_start_prompt: assert property (
    mst & !cfg.framed_mode_enable & !status.config_error & !status.busy
    & !status.tx_buffer_empty |-> ##[1:8] status.busy)
    else $error("no start");
  cover property (status.config_error);
  cover property (act);
  cover property ($rose(status.sample_phase_active));
  cover property ($fell(status.busy));
endmodule
bind sfm_port sfm_port_checker u_chk (.ref_clk(ref_clk), .rst(rst),
  .cfg(cfg), .tx_valid(tx_valid), .tx_ready(tx_ready), .status(status),
  .sck_out(sck_out), .ss_out(ss_out), .ss_oe(ss_oe));

// ---- test/sfm_slave_model.sv ----
`timescale 1ns/10ps
module sfm_slave_model (
  input  wire logic        sck,
  input  wire logic        cpol,
  input  wire logic        mosi,
  input  wire logic [15:0] word,
  input  wire logic        load,
  output logic             miso,
  output logic [15:0]      got
);
  logic [15:0] sh;
  int          n;
  logic        lead;
  // The leading edge leaves the idle level, whichever level that is.
  assign lead = sck ^ cpol;
  initial begin
    miso = 1'b1;
    n = 16;
    got = '0;
  end
  // The word is preloaded before the master starts, so bit 15 waits.
  always @(posedge load) begin
    sh = word;
    n = 0;
    miso = word[15];
  end
  always @(posedge lead) begin
    got = {got[14:0], mosi};
    n = n + 1;
  end
  // Released after the last bit; a flipped level stands for a floating line.
  always @(negedge lead) begin
    sh = sh << 1;
    miso = (n < 16) ? sh[15] : ~miso;
  end
endmodule

// ---- test/test_sfm_port.sv ----
`timescale 1ns/10ps
module test_sfm_port
  import sfm_pkg::*;
;
  logic        ref_clk = 1'b0;
  logic        rst = 1'b1;
  sfm_cfg_t    cfg = '0;
  logic [15:0] tx_data = '0;
  logic [15:0] sl_word = '0;
  logic        tx_valid = 1'b0;
  logic        rx_ack = 1'b0;
  logic        sl_load = 1'b0;
  logic [15:0] rx_data, got;
  logic        tx_ready, rx_valid, sck_out, sck_oe, sdo, sdi;
  logic        ss_out, ss_oe, p;
  sfm_stat_t   status;
  int          err_total = 0;
  int          checks = 0;
  int          n;
  always #25 ref_clk = ~ref_clk;
  sfm_port DUT (.ref_clk(ref_clk), .rst(rst), .cfg(cfg), .clk_div(8'h00),
    .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .rx_data(rx_data), .rx_valid(rx_valid), .rx_ack(rx_ack),
    .status(status), .sck_in(1'b0), .sck_out(sck_out), .sck_oe(sck_oe),
    .sdi(sdi), .sdo(sdo), .ss_in(1'b1), .ss_out(ss_out), .ss_oe(ss_oe));
  sfm_slave_model slave (.sck(sck_out), .cpol(cfg.clock_idle_polarity),
    .mosi(sdo), .word(sl_word),
    .load(sl_load), .miso(sdi), .got(got));
  task automatic ck(input logic ok, input string msg);
    checks++;
    if (ok !== 1'b1) begin
      err_total++;
      $display("[ERR] %0t %s", $time, msg);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge ref_clk);
    #1;
  endtask
  // Holds valid until an edge sees ready, then idles one cycle.
  task automatic push(input logic [15:0] w);
    tx_data = w;
    tx_valid = 1'b1;
    @(posedge ref_clk);
    while (tx_ready !== 1'b1) @(posedge ref_clk);
    #1 tx_valid = 1'b0;
    tick(1);
  endtask
  task automatic get_rx;
    repeat (200) begin
      if (rx_valid === 1'b1) break;
      tick(1);
    end
    ck(rx_valid === 1'b1 && status.rx_word_ready === 1'b1, "no word");
    rx_ack = 1'b1;
    tick(1);
    rx_ack = 1'b0;
  endtask
  // Preloads the far side first, then sends one word and checks both ends.
  task automatic swap(input logic [15:0] mine, input logic [15:0] theirs,
                      input string msg);
    sl_word = theirs;
    sl_load = 1'b1;
    tick(1);
    sl_load = 1'b0;
    push(mine);
    get_rx;
    ck(rx_data === theirs && got === mine, msg);
  endtask
  task automatic wrap_up;
    if (err_total == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    #500000;
    err_total++;
    wrap_up;
  end
  initial begin
    tick(5);
    rst = 1'b0;
    tick(1);
    ck(sck_out === 1'b0 && sck_oe === 1'b0 && rx_valid === 1'b0,
       "reset outputs");
    ck(status.tx_buffer_empty === 1'b1, "empty after reset");
    cfg.port_enable = 1'b1;
    cfg.master_role_enable = 1'b1;
    sl_word = 16'ha5c3;
    sl_load = 1'b1;
    tick(1);
    sl_load = 1'b0;
    push(16'h3c5a);
    get_rx;
    ck(rx_data === 16'ha5c3 && got === 16'h3c5a, "data swap");
    ck(status.tx_buffer_empty === 1'b1, "buffer kept word");
    cfg.port_enable = 1'b0;
    for (int i = 1; i <= 4; i++) push({12'h000, i[3:0]});
    ck(tx_ready === 1'b0 && status.tx_buffer_empty === 1'b0, "full");
    cfg.port_enable = 1'b1;
    repeat (4) get_rx;
    ck(got === 16'h0004 && status.tx_buffer_empty === 1'b1, "drain");
    // The forbidden pair is set on purpose to see transfers blocked.
    cfg.framed_mode_enable = 1'b1;
    cfg.slave_select_pin_enable = 1'b1;
    push(16'h00ff);
    tick(60);
    ck(status.config_error === 1'b1 && status.busy === 1'b0, "ran");
    ck(status.tx_buffer_empty === 1'b0, "bad pair took word");
    cfg.framed_mode_enable = 1'b0;
    cfg.slave_select_pin_enable = 1'b0;
    get_rx;
    cfg.master_role_enable = 1'b0;
    cfg.input_sample_phase = 1'b1;
    tick(3);
    ck(status.sample_phase_active === 1'b0, "phase w/o master");
    cfg.input_sample_phase = 1'b0;
    cfg.master_role_enable = 1'b1;
    tick(1);
    cfg.input_sample_phase = 1'b1;
    tick(3);
    ck(status.sample_phase_active === 1'b1, "phase not taken");
    swap(16'h0ff0, 16'h9e61, "late sample");
    cfg.input_sample_phase = 1'b0;
    cfg.clock_idle_polarity = 1'b1;
    tick(3);
    ck(sck_out === 1'b1 && sck_oe === 1'b1, "idle level high");
    swap(16'hc3a5, 16'h1b2d, "high idle swap");
    cfg.clock_idle_polarity = 1'b0;
    tick(3);
    for (int k = 0; k < 2; k++) begin
      cfg.frame_sync_polarity = k[0];
      cfg.framed_mode_enable = 1'b1;
      tick(2);
      n = 0;
      p = sck_out;
      repeat (20) begin
        tick(1);
        if (sck_out !== p) n++;
        p = sck_out;
      end
      ck(n == 20, "clock stopped");
      push(16'h5a5a);
      repeat (100) begin
        if (ss_oe === 1'b1 && ss_out === k[0]) break;
        tick(1);
      end
      ck(ss_oe === 1'b1 && ss_out === k[0], "no sync pulse");
      get_rx;
      cfg.framed_mode_enable = 1'b0;
      tick(3);
    end
    wrap_up;
  end
endmodule
